// File: include/dcpwm_defs.svh
// Constants of the dual channel pulse width modulator: register
// addresses, field positions, reset values and period base counts.
// Assumes nothing; definitions only.
`ifndef DCPWM_DEFS_SVH
`define DCPWM_DEFS_SVH

// Register addresses on the special function register bus
`define DCPWM_ADDR_DUTY_CH0 8'ha1
`define DCPWM_ADDR_DUTY_CH1 8'ha2
`define DCPWM_ADDR_CONTROL 8'hb2

// Reset values
`define DCPWM_RST_CONTROL 8'h00
`define DCPWM_RST_DUTY 8'h00

// Field positions in pulse_control
`define DCPWM_WIDTH_HI 7
`define DCPWM_WIDTH_LO 6
`define DCPWM_PRESC_HI 5
`define DCPWM_PRESC_LO 2
`define DCPWM_EN_CH1 1
`define DCPWM_EN_CH0 0

// Base count of one period, per width code (2^width - 1)
`define DCPWM_BASE_5 8'h1f
`define DCPWM_BASE_6 8'h3f
`define DCPWM_BASE_7 8'h7f
`define DCPWM_BASE_8 8'hff

// Read value of an unmapped address
`define DCPWM_RD_NONE 8'h00

`endif

// File: include/dcpwm_pkg.sv
// Types of the dual channel pulse width modulator.
// Assumes the constants header is included by its users.
package dcpwm_pkg;
	// Counter width selected by the two top bits of pulse_control
	typedef enum logic [1:0] {
		DCPWM_W5,
		DCPWM_W6,
		DCPWM_W7,
		DCPWM_W8
	} dcpwm_width_t;
endpackage

// File: design/dcpwm_top.sv
// Dual channel pulse width modulator with its three registers on the
// special function register bus of the controller core.
// Assumes the bus is synchronous to clk_sys_i and strobes last one cycle.
`timescale 1ns/100ps
`include "dcpwm_defs.svh"

module dcpwm_top (
	input wire logic clk_sys_i, // Core clock, 50 MHz
	input wire logic nrst_i, // Asynchronous reset, active low
	input wire logic [7:0] sfr_addr_i, // Register address
	input wire logic [7:0] sfr_wdata_i, // Write data
	input wire logic sfr_wr_i, // Write strobe, one cycle
	input wire logic sfr_rd_i, // Read strobe, one cycle
	output logic [7:0] sfr_rdata_o, // Read data, one cycle after strobe
	output logic pulse_out_ch0_o, // Channel 0 pin
	output logic pulse_out_ch1_o // Channel 1 pin
);

	logic [7:0] ctl_ff;
	logic [7:0] duty_ff [2];
	logic [3:0] pre_ff;
	logic [7:0] cnt_ff;
	logic [1:0] out_ff;
	logic [7:0] rdata_ff;
	logic [7:0] base;
	logic [3:0] presc;
	logic [1:0] en;
	logic tick;
	logic period_end;
	dcpwm_pkg::dcpwm_width_t width;

	// Decode of the shared control fields
	assign width = dcpwm_pkg::dcpwm_width_t'(
		ctl_ff[`DCPWM_WIDTH_HI:`DCPWM_WIDTH_LO]);
	assign presc = ctl_ff[`DCPWM_PRESC_HI:`DCPWM_PRESC_LO];
	assign en = {ctl_ff[`DCPWM_EN_CH1], ctl_ff[`DCPWM_EN_CH0]};

	// Base count doubles as the duty mask, since it is all ones
	always_comb begin
		unique case (width)
			dcpwm_pkg::DCPWM_W5: base = `DCPWM_BASE_5;
			dcpwm_pkg::DCPWM_W6: base = `DCPWM_BASE_6;
			dcpwm_pkg::DCPWM_W7: base = `DCPWM_BASE_7;
			dcpwm_pkg::DCPWM_W8: base = `DCPWM_BASE_8;
		endcase
	end

	// Control register write
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctl_ff <= `DCPWM_RST_CONTROL;
		end else if (sfr_wr_i && sfr_addr_i == `DCPWM_ADDR_CONTROL) begin
			ctl_ff <= sfr_wdata_i;
		end
	end

	// Read path; unmapped addresses read as zero
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_ff <= `DCPWM_RD_NONE;
		end else if (sfr_rd_i) begin
			unique case (sfr_addr_i)
				`DCPWM_ADDR_CONTROL: rdata_ff <= ctl_ff;
				`DCPWM_ADDR_DUTY_CH0: rdata_ff <= duty_ff[0];
				`DCPWM_ADDR_DUTY_CH1: rdata_ff <= duty_ff[1];
				default: rdata_ff <= `DCPWM_RD_NONE;
			endcase
		end
	end
	assign sfr_rdata_o = rdata_ff;

	// Prescaler: one tick every presc+1 core clocks
	// A prescale lowered mid count ticks at once rather than running to 15
	assign tick = (pre_ff >= presc);
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_ff <= 4'h0;
		end else if (tick) begin
			pre_ff <= 4'h0;
		end else begin
			pre_ff <= pre_ff + 4'h1;
		end
	end

	// Shared period counter; >= covers a width shrunk mid period
	assign period_end = (cnt_ff >= base - 8'h01);
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_ff <= 8'h00;
		end else if (tick) begin
			if (period_end) begin
				cnt_ff <= 8'h00;
			end else begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end

	// Per channel duty register and output; the comparison uses the duty
	// register directly, so a write moves the edge in the running period
	// and that period's duty lands between old and new
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic [7:0] duty_addr;
		assign duty_addr = (ch == 0) ? `DCPWM_ADDR_DUTY_CH0
			: `DCPWM_ADDR_DUTY_CH1;

		always_ff @(posedge clk_sys_i or negedge nrst_i) begin
			if (!nrst_i) begin
				duty_ff[ch] <= `DCPWM_RST_DUTY;
			end else if (sfr_wr_i && sfr_addr_i == duty_addr) begin
				duty_ff[ch] <= sfr_wdata_i;
			end
		end

		always_ff @(posedge clk_sys_i or negedge nrst_i) begin
			if (!nrst_i) begin
				out_ff[ch] <= 1'b0;
			end else begin
				out_ff[ch] <= en[ch] && (cnt_ff < (duty_ff[ch] & base));
			end
		end
	end

	assign pulse_out_ch0_o = out_ff[0];
	assign pulse_out_ch1_o = out_ff[1];

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	sequence s_duty0_write;
		sfr_wr_i && sfr_addr_i == `DCPWM_ADDR_DUTY_CH0;
	endsequence

	sequence s_stable_cfg;
		$stable(ctl_ff) && $stable(duty_ff[0]) && $stable(duty_ff[1]);
	endsequence

	chk_base_code: assert property (
		base == 8'((9'h001 << (4'd5 + {2'b00, width})) - 9'h001))
		else $error("Base count does not match width code");

	chk_cnt_wrap: assert property (
		tick && period_end |=> cnt_ff == 8'h00)
		else $error("Period counter did not wrap at base count");

	chk_presc_hold: assert property (
		!tick |=> $stable(cnt_ff))
		else $error("Counter stepped between prescaler ticks");

	chk_cnt_step: assert property (
		tick && !period_end |=> cnt_ff == $past(cnt_ff) + 8'h01)
		else $error("Counter did not step on tick");

	chk_duty_mask: assert property (
		en[0] ##1 s_stable_cfg |-> pulse_out_ch0_o ==
			($past(cnt_ff) < ($past(duty_ff[0]) & base)))
		else $error("Channel 0 level not set by masked duty");

	chk_disable_low: assert property (
		!en[1] |=> !pulse_out_ch1_o)
		else $error("Disabled channel 1 drove its pin high");

	chk_write_now: assert property (
		s_duty0_write ##1 en[0] && tick && $stable(ctl_ff) |=>
			pulse_out_ch0_o ==
			($past(cnt_ff) < ($past(duty_ff[0]) & $past(base))))
		else $error("Duty write did not act at once");

	chk_shared_cnt: assert property (
		en == 2'b11 && duty_ff[0] == duty_ff[1] |=>
			pulse_out_ch0_o == pulse_out_ch1_o)
		else $error("Channels with equal duty disagree");

	chk_full_duty: assert property (
		en[0] && (duty_ff[0] & base) == base && cnt_ff < base
			|=> pulse_out_ch0_o)
		else $error("Full duty output dropped low");

	chk_duty_mask1: assert property (
		en[1] ##1 s_stable_cfg |-> pulse_out_ch1_o ==
			($past(cnt_ff) < ($past(duty_ff[1]) & base)))
		else $error("Channel 1 level not set by masked duty");

	chk_disable_ch0: assert property (
		!en[0] |=> !pulse_out_ch0_o)
		else $error("Disabled channel 0 drove its pin high");

	chk_presc_clear: assert property (
		tick |=> pre_ff == 4'h0)
		else $error("Prescaler did not restart after tick");

	// Register bus; a read beside a write sees the old value
	sequence s_ctl_write;
		sfr_wr_i && sfr_addr_i == `DCPWM_ADDR_CONTROL;
	endsequence

	chk_ctl_write: assert property (
		s_ctl_write |=> ctl_ff == $past(sfr_wdata_i))
		else $error("Control write did not land");

	chk_duty0_write: assert property (
		s_duty0_write |=> duty_ff[0] == $past(sfr_wdata_i))
		else $error("Channel 0 duty write did not land");

	chk_duty1_write: assert property (
		sfr_wr_i && sfr_addr_i == `DCPWM_ADDR_DUTY_CH1 |=>
			duty_ff[1] == $past(sfr_wdata_i))
		else $error("Channel 1 duty write did not land");

	chk_read_ctl: assert property (
		sfr_rd_i && sfr_addr_i == `DCPWM_ADDR_CONTROL |=>
			sfr_rdata_o == $past(ctl_ff))
		else $error("Control read returned wrong value");

	chk_rdata_hold: assert property (
		!sfr_rd_i |=> $stable(sfr_rdata_o))
		else $error("Read data changed without a read");

endmodule

// File: verif/tb_top.sv
// Self-checking bench of the dual channel pulse width modulator.
// Assumes the design carries its own embedded timing assertions.
`timescale 1ns/100ps
`include "dcpwm_defs.svh"
module tb_top;
	logic clk_sys_i, nrst_i, sfr_wr_i, sfr_rd_i;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, rv, ctl, d0, d1, bs;
	logic pulse_out_ch0_o, pulse_out_ch1_o;
	logic [31:0] seed = 32'h71de_f114;
	int fail_count = 0;
	int samples_checked = 0;
	int per, h0, h1;
	dcpwm_top u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
		.sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
		.pulse_out_ch0_o(pulse_out_ch0_o), .pulse_out_ch1_o(pulse_out_ch1_o));
	// Core clock, 20 ns period
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	// Repeatable xorshift source
	function logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Base count 2^width - 1 for a width code
	function logic [7:0] base_of(input logic [1:0] w);
		return 8'((9'h020 << w) - 9'h001);
	endfunction
	// Strobes are dropped a half cycle after the sampling edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		@(negedge clk_sys_i);
		sfr_wr_i = 1'b0;
	endtask
	task chk_cnt(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			fail_count++;
			$display("ERROR %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	// Pin levels compared four-state, so an unknown level fails
	task chk_pin(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t pin %b expected %b", $time, got, exp);
		end
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys_i);
		sfr_addr_i = a;
		sfr_rd_i = 1'b1;
		@(negedge clk_sys_i);
		sfr_rd_i = 1'b0;
		samples_checked++;
		if (sfr_rdata_o !== exp) begin
			fail_count++;
			$display("ERROR %0t read %h expected %h", $time, sfr_rdata_o, exp);
		end
	endtask
	// High cycles of both pins over one period; order of phase is free
	task measure();
		h0 = 0;
		h1 = 0;
		repeat (per) begin
			@(negedge clk_sys_i);
			h0 += int'(pulse_out_ch0_o === 1'b1);
			h1 += int'(pulse_out_ch1_o === 1'b1);
		end
	endtask
	task results();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial begin
		nrst_i = 1'b0;
		sfr_wr_i = 1'b0;
		sfr_rd_i = 1'b0;
		sfr_addr_i = 8'h00;
		sfr_wdata_i = 8'h00;
		repeat (4) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		rd_chk(8'ha1, 8'h00);
		rd_chk(8'ha2, 8'h00);
		rd_chk(8'hb2, 8'h00);
		wr(8'hb3, 8'hff);
		rd_chk(8'hb3, 8'h00);
		// Full then zero duty must reach the pin within two edges
		wr(8'hb2, 8'h01);
		wr(8'ha1, 8'h1f);
		repeat (2) @(negedge clk_sys_i);
		chk_pin(pulse_out_ch0_o, 1'b1);
		chk_pin(pulse_out_ch1_o, 1'b0);
		wr(8'ha1, 8'h00);
		repeat (2) @(negedge clk_sys_i);
		chk_pin(pulse_out_ch0_o, 1'b0);
		// Duty change in mid period stays between old and new
		wr(8'ha1, 8'h0a);
		per = 31;
		repeat (33) @(negedge clk_sys_i);
		fork
			measure();
			begin
				repeat (12) @(negedge clk_sys_i);
				wr(8'ha1, 8'h14);
			end
		join
		chk_cnt(int'(h0 >= 10 && h0 <= 20), 1);
		// Random settings cover every width code twice
		for (int i = 0; i < 8; i++) begin
			rv = rnd();
			ctl = {i[1:0], rv[5:2], ((i == 3) ? 2'b11 : rv[1:0])};
			d0 = (i == 3) ? 8'hff : rnd();
			d1 = (i == 3) ? 8'hff : rnd();
			wr(8'hb2, ctl);
			wr(8'ha1, d0);
			wr(8'ha2, d1);
			rd_chk(8'hb2, ctl);
			rd_chk(8'ha2, d1);
			rd_chk(8'ha1, d0);
			bs = base_of(ctl[7:6]);
			per = int'(bs) * (int'(ctl[5:2]) + 1);
			repeat (per + 2) @(negedge clk_sys_i);
			measure();
			chk_cnt(h0, ctl[0] ? int'(d0 & bs) * (int'(ctl[5:2]) + 1) : 0);
			chk_cnt(h1, ctl[1] ? int'(d1 & bs) * (int'(ctl[5:2]) + 1) : 0);
		end
		// Reset in mid run clears pins at once and registers to zero
		@(negedge clk_sys_i);
		nrst_i = 1'b0;
		@(negedge clk_sys_i);
		chk_pin(pulse_out_ch0_o, 1'b0);
		chk_pin(pulse_out_ch1_o, 1'b0);
		repeat (3) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		rd_chk(8'hb2, 8'h00);
		rd_chk(8'ha1, 8'h00);
		rd_chk(8'ha2, 8'h00);
		results();
	end
endmodule
